// ===== logic/ctc_ctrl.sv
// Controller for an external 512x9 cache tag store and comparator slice.
// Assumes the store is asynchronous; match and fault pins are synchronised here.
// Contract
// - Write is chip select low together with write strobe low, at index.
// - Holding parity fault pin low during a write stores a bad word.
// - Wider tags use parallel 8-bit slices; hit needs every slice match.
// - Two-slice systems gate matches to enable data buffers.
// - System write strobe writes data RAMs and tag together.
// - Reset pulse low at least 35 ns clears all, match goes high.
// - Compare is chip select low with write strobe high.
`timescale 1ns/1ns
`default_nettype none
`include "ctc_map.svh"
module ctc_ctrl
    import ctc_pkg::*;
(
    input  wire logic                   sys_clk,          // 10 MHz clock
    input  wire logic                   rst,              // Async reset, high
    input  wire logic                   req_init,         // Start store clear
    input  wire logic                   req_write,        // Start tag write
    input  wire logic                   req_cmp,          // Start tag compare
    input  wire logic                   req_force_fault,  // Write with bad parity
    input  wire logic [`CTC_INDEX_W-1:0] req_index,       // Index for request
    input  wire logic [`CTC_TAG_W-1:0]   req_tag,         // Tag for request
    output logic                        busy,             // Request in progress
    output logic                        done,             // Pulse, request done
    output logic                        hit,              // Compare matched
    output logic                        fault,            // Compare parity fault
    output logic                        store_reset_n,    // Store reset pin
    output logic                        chip_sel_n,       // Store chip select
    output logic                        write_n,          // Store write strobe
    output logic [`CTC_INDEX_W-1:0]     tag_index,        // Store index pins
    output logic [`CTC_TAG_W-1:0]       tag_compare_bits, // Store tag pins
    input  wire logic                   match_in,         // Store match pin
    input  wire logic                   parity_fault_n_i, // Fault pin level
    output logic                        parity_fault_n_o, // Fault pin drive value
    output logic                        parity_fault_n_oe // Fault pin enable
);
    // All sequencer state, registered as one word
    typedef struct packed {
        ctc_state_type             st;
        logic [3:0]                cnt;
        logic                      force_f;
        logic                      is_init;
        logic                      hit;
        logic                      fault;
        logic                      done;
        logic [`CTC_INDEX_W-1:0]   idx;
        logic [`CTC_TAG_W-1:0]     tag;
    } ctc_ctrl_type;
    ctc_ctrl_type r_q, r_d;

    // Cycle counts for the reset pulse and the compare settle
    localparam logic [3:0] RST_CYC = 4'(`CTC_RST_CYC);
    localparam logic [3:0] CMP_CYC = 4'(`CTC_CMP_WAIT);

    // Counter step, shared by the reset and compare waits
    function automatic logic [3:0] cnt_inc(input logic [3:0] c);
        return c + 4'h1;
    endfunction

    // True while the sequencer sits in the given state
    function automatic logic in_state(input ctc_state_type cur, input ctc_state_type want);
        return cur == want;
    endfunction

    logic match_s;
    logic fault_n_s;
    logic slice_hit_gate;  // AND of every slice match

    // Synchronise the match and fault pins
    ctc_sync2 u_sync_match (
        .sys_clk (sys_clk),
        .rst     (rst),
        .rst_val (1'b0),
        .d       (match_in),
        .q       (match_s)
    );
    ctc_sync2 u_sync_fault (
        .sys_clk (sys_clk),
        .rst     (rst),
        .rst_val (1'b1),
        .d       (~parity_fault_n_i),
        .q       (fault_n_s)
    );

    // One slice here; further slices add their match to this AND
    assign slice_hit_gate = &{match_s};

    // Sequencer for clear, write and compare
    always_comb
    begin
        r_d      = r_q;
        r_d.done = 1'b0;
        case (r_q.st)
            ST_IDLE:
            begin
                // Take a request; init before write before compare
                r_d.cnt = 4'h0;
                if (req_init)
                begin
                    r_d.st      = ST_RESET;
                    r_d.is_init = 1'b1;
                end
                else if (req_write)
                begin
                    r_d.st      = ST_WRITE;
                    r_d.idx     = req_index;
                    r_d.tag     = req_tag;
                    r_d.force_f = req_force_fault;
                    r_d.is_init = 1'b0;
                end
                else if (req_cmp)
                begin
                    r_d.st      = ST_CMP;
                    r_d.idx     = req_index;
                    r_d.tag     = req_tag;
                    r_d.force_f = 1'b0;
                    r_d.is_init = 1'b0;
                end
            end
            ST_RESET:
            begin
                // Hold reset low for the least pulse width
                r_d.cnt = cnt_inc(r_q.cnt);
                if (cnt_inc(r_q.cnt) >= RST_CYC)
                begin
                    r_d.st = ST_DONE;
                    r_d.hit   = 1'b0;
                    r_d.fault = 1'b0;
                end
            end
            ST_WRITE:
            begin
                // One cycle with both strobes low lands the write
                r_d.st = ST_DONE;
            end
            ST_CMP:
            begin
                // Wait for pins to settle through the synchroniser
                r_d.cnt = cnt_inc(r_q.cnt);
                if (cnt_inc(r_q.cnt) >= CMP_CYC)
                begin
                    r_d.st    = ST_DONE;
                    r_d.fault = ~fault_n_s;
                    r_d.hit   = slice_hit_gate & fault_n_s;
                end
            end
            ST_DONE:
            begin
                // Back to idle; done pulses for one cycle, the first idle cycle
                r_d.done = 1'b1;
                r_d.st   = ST_IDLE;
            end
            default:
            begin
                r_d.st = ST_IDLE;  // Recover from an illegal code
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            r_q     <= '0;
            r_q.st  <= ST_IDLE;
        end
        else
            r_q <= r_d;
    end

    // Pin drive: strobes decoded from state
    assign store_reset_n     = ~in_state(r_q.st, ST_RESET);
    assign chip_sel_n        = ~(in_state(r_q.st, ST_WRITE)
                                 | in_state(r_q.st, ST_CMP));
    assign write_n           = ~in_state(r_q.st, ST_WRITE);
    assign tag_index         = r_q.idx;
    assign tag_compare_bits  = r_q.tag;
    assign parity_fault_n_o  = 1'b0;
    assign parity_fault_n_oe = in_state(r_q.st, ST_WRITE) & r_q.force_f;
    assign busy              = ~in_state(r_q.st, ST_IDLE);
    assign done              = r_q.done;
    assign hit               = r_q.hit;
    assign fault             = r_q.fault;

    // Checks
    a_write_strobe: assert property (@(posedge sys_clk) disable iff (rst)
        !write_n |-> !chip_sel_n) else $error("write without select");
    a_write_len: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(write_n) |=> write_n) else $error("write not one cycle");
    a_force_only_wr: assert property (@(posedge sys_clk) disable iff (rst)
        parity_fault_n_oe |-> !write_n) else $error("fault drive off write");
    a_reset_len: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(store_reset_n) |-> (r_q.is_init && (r_q.cnt >= RST_CYC)))
        else $error("reset short");
    a_cmp_strobe: assert property (@(posedge sys_clk) disable iff (rst)
        (r_q.st == ST_CMP) |-> (!chip_sel_n && write_n)) else $error("compare strobe");
    a_fault_no_hit: assert property (@(posedge sys_clk) disable iff (rst)
        fault |-> !hit) else $error("hit with fault");
    a_cmp_done: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(r_q.st == ST_CMP) |-> ##4 done) else $error("compare late");
    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        !busy |-> (chip_sel_n && write_n && store_reset_n)) else $error("idle strobe");
    a_result_hold: assert property (@(posedge sys_clk) disable iff (rst)
        ($changed(hit) || $changed(fault)) |-> (r_q.st == ST_DONE))
        else $error("result moved off done");

    // Main scenarios
    c_write: cover property (@(posedge sys_clk) disable iff (rst) !write_n);
    c_hit: cover property (@(posedge sys_clk) disable iff (rst) done && hit);
    c_fault: cover property (@(posedge sys_clk) disable iff (rst) done && fault);
    c_init: cover property (@(posedge sys_clk) disable iff (rst) !store_reset_n);
    c_force_write: cover property (@(posedge sys_clk) disable iff (rst) parity_fault_n_oe);
endmodule // ctc_ctrl
`default_nettype wire

// ===== logic/ctc_map.svh
// Constants for the cache tag store controller.
// Assumes inclusion by bare name from logic files.
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH

`define CTC_INDEX_W      9
`define CTC_TAG_W        8
`define CTC_CLK_NS       100
`define CTC_RST_MIN_NS   35
// Least reset pulse, rounded up to whole cycles, at least one
`define CTC_RST_CYC      ((`CTC_RST_MIN_NS + `CTC_CLK_NS - 1) / `CTC_CLK_NS)
// Cycles a compare waits for the result to settle and be sampled
`define CTC_CMP_WAIT     3

`endif

// ===== logic/ctc_pkg.sv
// Types for the cache tag store controller.
// Assumes ctc_map.svh is on the include path.
`include "ctc_map.svh"
package ctc_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_RESET = 5'h02,
        ST_WRITE = 5'h04,
        ST_CMP   = 5'h08,
        ST_DONE  = 5'h10
    } ctc_state_type;
endpackage

// ===== logic/ctc_sync2.sv
// Two-flop synchroniser for pins from the tag store.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module ctc_sync2
    import ctc_pkg::*;
(
    input  wire logic sys_clk,   // System clock
    input  wire logic rst,       // Async reset, high
    input  wire logic rst_val,   // Value held while in reset
    input  wire logic d,         // Asynchronous level
    output logic      q          // Synchronised level XOR rst_val
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ctc_sync_type;
    ctc_sync_type r_q, r_d;

    // Second flop alone reads the first
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    // Registers, constant on reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign q = r_q.s2 ^ rst_val;
endmodule // ctc_sync2
`default_nettype wire

// ===== verification/ctc_store_model.sv
// Behavioural 512 x 9 tag store slice for the controller bench.
// Assumes the bench resolves the pulled-up fault line from all drivers.
`timescale 1ns/1ns
`default_nettype none
module ctc_store_model (
    input  wire logic       reset_n,    // Clear pulse, low
    input  wire logic       cs_n,       // Chip select, low
    input  wire logic       w_n,        // Write strobe, low
    input  wire logic [8:0] index,      // Word index
    input  wire logic [7:0] tag,        // Tag bits
    input  wire logic       fault_line, // Resolved fault line
    output logic            match,      // Match pin
    output logic            fault_oe    // Pulls fault line low
);
    logic [8:0] mem [512];
    logic [8:0] word;
    logic       wr_on;     // Write pulse under way
    logic       wr_forced; // Fault line seen low in this pulse

    // Clear on reset; a write lands as its strobes rise, with own even
    // parity, or bad parity if the fault line was low during the pulse
    always @(negedge reset_n or cs_n or w_n or index or tag or fault_line)
    begin
        if (!reset_n)
        begin
            for (int k = 0; k < 512; k++)
                mem[k] = 9'h000;
            wr_on     = 1'b0;
            wr_forced = 1'b0;
        end
        else if (!cs_n && !w_n)
        begin
            wr_on = 1'b1;
            if (!fault_line)
                wr_forced = 1'b1;
        end
        else if (wr_on)
        begin
            mem[index] = {(^tag) ^ wr_forced, tag};
            wr_on      = 1'b0;
            wr_forced  = 1'b0;
        end
    end

    // Compare only; stored bits never leave the model
    assign word = mem[index];
    assign fault_oe = reset_n && !cs_n && w_n && (^word);
    assign match = !reset_n || (!cs_n && w_n && !(^word) && word[7:0] == tag);
endmodule // ctc_store_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the tag store controller.
// Assumes ctc_store_model stands on the far side of the store pins.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic       sys_clk = 0, rst = 1, req_init = 0, req_write = 0, req_cmp = 0;
    logic       req_force_fault = 0;
    logic [8:0] req_index = 9'h000;
    logic [7:0] req_tag = 8'h00;
    logic       busy, done, hit, fault, store_reset_n, chip_sel_n, write_n;
    logic       pf_o, pf_oe, match_in, mdl_oe, fault_line;
    logic [8:0] tag_index;
    logic [7:0] tag_compare_bits;
    int         n_mismatch = 0, checks_done = 0, cycles = 0;

    ctc_ctrl uut (.sys_clk(sys_clk), .rst(rst), .req_init(req_init), .req_write(req_write),
        .req_cmp(req_cmp), .req_force_fault(req_force_fault), .req_index(req_index),
        .req_tag(req_tag), .busy(busy), .done(done), .hit(hit), .fault(fault),
        .store_reset_n(store_reset_n), .chip_sel_n(chip_sel_n), .write_n(write_n),
        .tag_index(tag_index), .tag_compare_bits(tag_compare_bits), .match_in(match_in),
        .parity_fault_n_i(fault_line), .parity_fault_n_o(pf_o), .parity_fault_n_oe(pf_oe));
    ctc_store_model mdl (.reset_n(store_reset_n), .cs_n(chip_sel_n), .w_n(write_n),
        .index(tag_index), .tag(tag_compare_bits), .fault_line(fault_line),
        .match(match_in), .fault_oe(mdl_oe));

    // Pulled-up wired fault line
    assign fault_line = !((pf_oe && !pf_o) || mdl_oe);

    // Clock and hang guard
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task conclude;
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One request: 0 init, 1 write, 2 compare; waits for done
    task run(input int k, input logic [8:0] i, input logic [7:0] t, input logic ff);
        int n;
        n = 0;
        @(posedge sys_clk);
        #5;
        req_init = (k == 0);
        req_write = (k == 1);
        req_cmp = (k == 2);
        req_force_fault = ff;
        req_index = i;
        req_tag = t;
        @(posedge sys_clk);
        #5;
        req_init = 0;
        req_write = 0;
        req_cmp = 0;
        chk({7'h00, busy}, 8'h01);
        if (k == 0)
            chk({7'h00, store_reset_n}, 8'h00);
        if (k == 1)
        begin
            chk({6'h00, chip_sel_n, write_n}, 8'h00);
            chk(tag_compare_bits, t);
            chk(tag_index[7:0], i[7:0]);
            chk({7'h00, tag_index[8]}, {7'h00, i[8]});
            chk({6'h00, pf_oe, pf_o}, {6'h00, ff, 1'b0});
        end
        if (k == 2)
            chk({6'h00, chip_sel_n, write_n}, 8'h01);
        while (done !== 1'b1 && n < 10)
        begin
            @(posedge sys_clk);
            #5;
            n++;
        end
        chk({7'h00, done}, 8'h01);
        chk({7'h00, busy}, 8'h00);
    endtask

    task cmp(input logic [8:0] i, input logic [7:0] t, input logic eh, input logic ef);
        run(2, i, t, 1'b0);
        chk({6'h00, hit, fault}, {6'h00, eh, ef});
    endtask

    // Scenarios
    task s_init;
        run(0, 9'h000, 8'h00, 1'b0);
        chk({6'h00, hit, fault}, 8'h00);
        cmp(9'h005, 8'h00, 1'b1, 1'b0);
    endtask

    task s_write;
        run(1, 9'h1ff, 8'ha5, 1'b0);
        cmp(9'h1ff, 8'ha5, 1'b1, 1'b0);
        cmp(9'h1ff, 8'ha4, 1'b0, 1'b0);
        cmp(9'h000, 8'ha5, 1'b0, 1'b0);
    endtask

    task s_force;
        run(1, 9'h000, 8'h3c, 1'b1);
        cmp(9'h000, 8'h3c, 1'b0, 1'b1);
        cmp(9'h1ff, 8'ha5, 1'b1, 1'b0);
    endtask

    task s_reinit;
        run(0, 9'h000, 8'h00, 1'b0);
        cmp(9'h1ff, 8'ha5, 1'b0, 1'b0);
        cmp(9'h000, 8'h00, 1'b1, 1'b0);
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk);
        #5;
        rst = 0;
        s_init();
        s_write();
        s_force();
        s_reinit();
        conclude();
    end
endmodule // tb_top
`default_nettype wire
